// ==== jtf_framer.sv ====
// Notes on behaviour
// [RL1] lanes run 8B/10B or 64B/66B line coding, chosen by link configuration
// [RL2] output spreads over at most eight lanes
// [RL3] 8B/10B output stays receivable by older JESD204B receivers
// [RL4] 64B/66B blocks carry a sync header; no SYNC handshake used
// [RL5] receiver pulls SYNC low to request init; device starts code group sync
// [RL6] 64B/66B ignores SYNC for init; used only for NCO synchronisation
// [RL7] SYSREF resets multiframe counter or extended multiblock counter deterministically
// [RL8] device clock runs all digital logic and the serializers
// [RL9] forward error correction is an option on 64B/66B lanes
// [RL10] no 64B/80B link layer, no CRC3, no command channel
// [RL11] subclass 1 transmitter only; works with subclass 0 receivers
// [RL12] lanes align within one link; no multipoint reference alignment
// [RL13] SYNC timing of both JESD204A and JESD204B conventions is accepted
// [RL14] samples pack into octets, F octets per frame, frames over L lanes
// [RL15] N-bit samples take N' bits; M converters, S samples per frame
// [RL16] one mode-select setting picks the whole transport parameter set
// [RL17] frames group into multiframes, or blocks, multiblocks, extended multiblocks
// [RL18] while SYNC is low in 8B/10B, all lanes send K28.5 commas; code sends them on active lanes only, inactive lanes send 00
// [RL19] after SYNC rises, wait for multiframe edge, then four-multiframe alignment sequence
// [RL20] scrambling always on in 64B/66B, optional in 8B/10B
// [RL21] single-channel variant limits active lanes to four
`timescale 1ns/100ps
module jtf_framer #(
	parameter int K_FRAMES    = jtf_pkg::K_FRAMES_DEF,
	parameter int EXT_MBLOCKS = jtf_pkg::EXT_MBLOCKS_DEF
) (
	// clock and reset
	input  wire logic                                   clk_sys,
	input  wire logic                                   sys_rst,
	// link configuration
	input  wire logic                                   line_enc_64b,
	input  wire logic [jtf_pkg::MODE_W-1:0]             transport_mode_select,
	input  wire logic                                   scramble_enable,
	input  wire logic                                   fec_enable,
	input  wire logic                                   nco_sync_enable,
	input  wire logic                                   single_channel,
	// pins from the receiver and the system
	input  wire logic                                   sync_n_pin,
	input  wire logic                                   sysref_pin,
	// sample stream
	input  wire logic                                   in_valid,
	input  wire logic [jtf_pkg::SAMPLES_PER_WORD*jtf_pkg::SAMPLE_N-1:0] in_samples,
	output logic                                        in_ready,
	// serializer side
	input  wire logic                                   ser_ready,
	output logic [jtf_pkg::LANES_MAX*jtf_pkg::OCTET_W-1:0] lane_octet,
	output logic [jtf_pkg::LANES_MAX-1:0]               lane_is_k,
	output logic [jtf_pkg::LANES_MAX-1:0]               lane_enable,
	output logic                                        octet_valid,
	output logic                                        hdr_valid,
	output logic [1:0]                                  lane_hdr,
	output logic                                        fec_active,
	output logic                                        nco_sync_pulse,
	output logic                                        link_up
);
	localparam int L_MAX = jtf_pkg::LANES_MAX;

	initial begin
		if (K_FRAMES < jtf_pkg::K_FRAMES_MIN || K_FRAMES > jtf_pkg::K_FRAMES_MAX || EXT_MBLOCKS < 1
			|| EXT_MBLOCKS > 8)
			$error("jtf_framer: frames per multiframe or multiblocks per extended multiblock out of range");
	end

	// pin synchronisers
	logic [1:0] sync_ff_reg;
	logic [1:0] sysref_ff_reg;
	logic       sysref_prev_reg;
	logic       sync_prev_reg;
	wire        sync_n_s     = sync_ff_reg[1];
	wire        sysref_s     = sysref_ff_reg[1];
	wire        sysref_edge  = sysref_s && !sysref_prev_reg;
	wire        sync_fall    = !sync_n_s && sync_prev_reg;

	// sync stages start low so a pin held low through reset shows no false edge
	always_ff @(posedge clk_sys or posedge sys_rst) begin // RL8
		if (sys_rst) begin
			sync_ff_reg     <= 2'h0;
			sysref_ff_reg   <= 2'h0;
			sysref_prev_reg <= 1'b0;
			sync_prev_reg   <= 1'b0;
		end else begin
			sync_ff_reg     <= {sync_ff_reg[0], sync_n_pin};
			sysref_ff_reg   <= {sysref_ff_reg[0], sysref_pin};
			sysref_prev_reg <= sysref_s;
			sync_prev_reg   <= sync_n_s;
		end
	end

	// transport mode decode
	wire [3:0]  lanes_mode = jtf_pkg::MODE_LANES[transport_mode_select]; // RL16
	wire [3:0]  lanes_act  = (single_channel && lanes_mode > 4'(jtf_pkg::LANES_SINGLE))
		? 4'(jtf_pkg::LANES_SINGLE) : lanes_mode; // RL21 RL2
	wire [3:0]  frame_oct  = (lanes_act == 4'h8) ? 4'h1 : (lanes_act == 4'h4) ? 4'h2 :
		(lanes_act == 4'h2) ? 4'h4 : 4'h8; // RL14
	wire [15:0] mf_len     = 16'(frame_oct) * 16'(K_FRAMES); // RL17
	wire [15:0] local_ext_multiblock_counter_len   = jtf_pkg::BLOCK_OCTETS * jtf_pkg::MBLOCK_BLOCKS * 16'(EXT_MBLOCKS); // RL17
	wire [15:0] reinit_len = 16'(frame_oct) * jtf_pkg::SYNC_REINIT_FRAMES;

	// samples widened to N' bits with zero tail bits, four to a word
	logic [jtf_pkg::WORD_W-1:0] packed_word;
	genvar s;
	generate
		for (s = 0; s < jtf_pkg::SAMPLES_PER_WORD; s++) begin : g_pack
			assign packed_word[jtf_pkg::WORD_W-1-s*jtf_pkg::SAMPLE_NP -: jtf_pkg::SAMPLE_NP] =
				{in_samples[(jtf_pkg::SAMPLES_PER_WORD-s)*jtf_pkg::SAMPLE_N-1 -: jtf_pkg::SAMPLE_N],
				 {(jtf_pkg::SAMPLE_NP-jtf_pkg::SAMPLE_N){1'b0}}}; // RL15
		end
	endgenerate

	logic                       buf_valid;
	logic [jtf_pkg::WORD_W-1:0] buf_word;
	logic                       buf_pop;

	jtf_buf #(
		.WIDTH (jtf_pkg::WORD_W),
		.DEPTH (jtf_pkg::BUF_DEPTH)
	) u_buf (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_valid  (in_valid),
		.in_data   (packed_word),
		.in_ready  (in_ready),
		.out_valid (buf_valid),
		.out_data  (buf_word),
		.out_ready (buf_pop)
	);

	// framing counters
	jtf_pkg::jtf_state_t state_reg;
	jtf_pkg::jtf_state_t state_next;
	logic [15:0]         local_multiframe_counter_reg;
	logic [15:0]         local_ext_multiblock_counter_reg;
	logic [1:0]          ilas_mf_reg;
	logic [3:0]          chunk_reg;
	logic [15:0]         sync_low_cnt_reg;
	wire                 tick      = ser_ready;
	wire                 mf_edge   = tick && (local_multiframe_counter_reg == mf_len - 16'h0001);
	wire                 local_ext_multiblock_counter_edge = tick && (local_ext_multiblock_counter_reg == local_ext_multiblock_counter_len - 16'h0001);
	wire                 chunk_last = (chunk_reg == frame_oct - 4'h1);
	wire                 in_data_st = (state_reg == jtf_pkg::ST_DATA);
	wire                 sync_reinit = !line_enc_64b && (sync_low_cnt_reg >= reinit_len - 16'h0001)
		&& !sync_n_s; // RL13
	wire                 scr_on    = line_enc_64b || scramble_enable; // RL20

	assign buf_pop = in_data_st && tick && chunk_last && buf_valid;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			jtf_pkg::ST_CGS: begin
				if (line_enc_64b)
					state_next = jtf_pkg::ST_WAIT; // RL6
				else if (sync_n_s)
					state_next = jtf_pkg::ST_WAIT; // RL5
			end
			jtf_pkg::ST_WAIT: begin
				if (line_enc_64b) begin
					if (local_ext_multiblock_counter_edge)
						state_next = jtf_pkg::ST_DATA; // RL4
				end else if (!sync_n_s) begin
					state_next = jtf_pkg::ST_CGS;
				end else if (mf_edge) begin
					state_next = jtf_pkg::ST_ILAS; // RL19
				end
			end
			jtf_pkg::ST_ILAS: begin
				if (sync_reinit)
					state_next = jtf_pkg::ST_CGS;
				else if (mf_edge && ilas_mf_reg == jtf_pkg::ILAS_LAST_MF)
					state_next = jtf_pkg::ST_DATA; // RL19
			end
			jtf_pkg::ST_DATA: begin
				if (sync_reinit)
					state_next = jtf_pkg::ST_CGS; // RL5 RL13
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg                        <= jtf_pkg::ST_CGS;
			local_multiframe_counter_reg     <= 16'h0000;
			local_ext_multiblock_counter_reg <= 16'h0000;
			ilas_mf_reg                      <= 2'h0;
			chunk_reg                        <= 4'h0;
			sync_low_cnt_reg                 <= 16'h0000;
		end else begin
			state_reg <= state_next;
			if (sysref_edge)
				local_multiframe_counter_reg <= 16'h0000; // RL7 RL11
			else if (mf_edge)
				local_multiframe_counter_reg <= 16'h0000;
			else if (tick)
				local_multiframe_counter_reg <= local_multiframe_counter_reg + 16'h0001;
			if (sysref_edge)
				local_ext_multiblock_counter_reg <= 16'h0000; // RL7 RL11
			else if (local_ext_multiblock_counter_edge)
				local_ext_multiblock_counter_reg <= 16'h0000;
			else if (tick)
				local_ext_multiblock_counter_reg <= local_ext_multiblock_counter_reg + 16'h0001;
			if (state_reg != jtf_pkg::ST_ILAS)
				ilas_mf_reg <= 2'h0;
			else if (mf_edge)
				ilas_mf_reg <= ilas_mf_reg + 2'h1;
			if (!in_data_st)
				chunk_reg <= 4'h0;
			else if (tick && buf_valid)
				chunk_reg <= chunk_last ? 4'h0 : chunk_reg + 4'h1; // RL14
			if (sync_n_s)
				sync_low_cnt_reg <= 16'h0000;
			else if (tick && sync_low_cnt_reg != 16'hFFFF)
				sync_low_cnt_reg <= sync_low_cnt_reg + 16'h0001;
		end
	end

	// self-synchronous scrambler, one octet msb first; taps follow the line coding
	function automatic logic [jtf_pkg::SCR_W+7:0] scr_octet(input logic [7:0] d,
		input logic [jtf_pkg::SCR_W-1:0] st, input logic enc64);
		logic [jtf_pkg::SCR_W-1:0] cur;
		logic [7:0]                q;
		logic                      b;
		cur = st;
		q   = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			b    = enc64 ? (d[i] ^ cur[jtf_pkg::SCR64_TAP_A] ^ cur[jtf_pkg::SCR64_TAP_B])
				: (d[i] ^ cur[jtf_pkg::SCR8_TAP_A] ^ cur[jtf_pkg::SCR8_TAP_B]);
			q[i] = b;
			cur  = {cur[jtf_pkg::SCR_W-2:0], b};
		end
		return {cur, q};
	endfunction

	// shared alignment-sequence octet, identical on every active lane so lanes align in one link
	wire [15:0] mf_pos    = local_multiframe_counter_reg;
	wire        ilas_k    = (mf_pos == 16'h0000) || (mf_pos == mf_len - 16'h0001)
		|| (ilas_mf_reg == 2'h1 && mf_pos == 16'h0001);
	wire [7:0]  ilas_oct  = (mf_pos == 16'h0000) ? jtf_pkg::CHAR_MF_START :
		(mf_pos == mf_len - 16'h0001) ? jtf_pkg::CHAR_MF_END :
		(ilas_mf_reg == 2'h1 && mf_pos == 16'h0001) ? jtf_pkg::CHAR_CFG_START : mf_pos[7:0]; // RL19 RL12

	genvar l;
	generate
		for (l = 0; l < L_MAX; l++) begin : g_lane
			logic [jtf_pkg::SCR_W-1:0] scr_reg;
			logic [7:0]                oct_reg;
			logic                      k_reg;
			logic                      en_reg;
			wire  [3:0]                idx     = 4'(chunk_reg * lanes_act) + 4'(l);
			wire  [7:0]                raw     = buf_valid ? buf_word[jtf_pkg::WORD_W-1-8*idx[2:0] -: 8] : 8'h00;
			wire  [jtf_pkg::SCR_W+7:0] scr_res = scr_octet(raw, scr_reg, line_enc_64b);
			wire                       active  = (4'(l) < lanes_act); // RL2 RL21
			wire                       comma   = !line_enc_64b &&
				(state_reg == jtf_pkg::ST_CGS || state_reg == jtf_pkg::ST_WAIT); // RL18 RL3
			wire                       ilas    = (state_reg == jtf_pkg::ST_ILAS);
			wire                       scr_use = in_data_st && scr_on && buf_valid; // RL20

			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					scr_reg <= '1;
					oct_reg <= 8'h00;
					k_reg   <= 1'b0;
					en_reg  <= 1'b0;
				end else begin
					en_reg <= active;
					if (tick) begin
						if (!active) begin
							oct_reg <= 8'h00;
							k_reg   <= 1'b0;
						end else if (comma) begin
							oct_reg <= jtf_pkg::CHAR_COMMA; // RL18
							k_reg   <= 1'b1;
						end else if (ilas) begin
							oct_reg <= ilas_oct; // RL19
							k_reg   <= ilas_k;
						end else if (scr_use) begin
							oct_reg <= scr_res[7:0]; // RL20
							k_reg   <= 1'b0;
							scr_reg <= scr_res[jtf_pkg::SCR_W+7:8];
						end else begin
							oct_reg <= in_data_st ? raw : 8'h00; // RL14
							k_reg   <= 1'b0;
						end
					end
				end
			end

			assign lane_octet[8*l +: 8] = oct_reg;
			assign lane_is_k[l]         = k_reg;
			assign lane_enable[l]       = en_reg;
		end
	endgenerate

	// link-wide status and block headers
	logic octet_valid_reg;
	logic hdr_valid_reg;
	logic [1:0] hdr_reg;
	logic fec_active_reg;
	logic nco_sync_reg;
	logic link_up_reg;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			octet_valid_reg <= 1'b0;
			hdr_valid_reg   <= 1'b0;
			hdr_reg         <= 2'h0;
			fec_active_reg  <= 1'b0;
			nco_sync_reg    <= 1'b0;
			link_up_reg     <= 1'b0;
		end else begin
			octet_valid_reg <= tick; // RL8
			hdr_valid_reg   <= tick && line_enc_64b &&
				(local_ext_multiblock_counter_reg[2:0] == 3'h0); // RL4 RL17
			hdr_reg         <= line_enc_64b ? jtf_pkg::HDR_DATA : 2'h0; // RL4 RL10
			fec_active_reg  <= line_enc_64b && fec_enable; // RL9
			nco_sync_reg    <= line_enc_64b && nco_sync_enable && sync_fall; // RL6
			link_up_reg     <= (state_next == jtf_pkg::ST_DATA); // RL1
		end
	end

	assign octet_valid    = octet_valid_reg;
	assign hdr_valid      = hdr_valid_reg;
	assign lane_hdr       = hdr_reg;
	assign fec_active     = fec_active_reg;
	assign nco_sync_pulse = nco_sync_reg;
	assign link_up        = link_up_reg;
endmodule

// ==== jtf_pkg.sv ====
package jtf_pkg;
	localparam int          LANES_MAX          = 8;
	localparam int          LANES_SINGLE       = 4;
	localparam int          OCTET_W            = 8;
	localparam int          SAMPLE_N           = 12;
	localparam int          SAMPLE_NP          = 16;
	localparam int          SAMPLES_PER_WORD   = 4;
	localparam int          WORD_W             = 64;
	localparam int          WORD_OCTETS        = 8;
	localparam int          MODE_W             = 2;
	localparam int          CNT_W              = 16;
	localparam int          SCR_W              = 58;
	localparam int          SCR8_TAP_A         = 13;
	localparam int          SCR8_TAP_B         = 14;
	localparam int          SCR64_TAP_A        = 38;
	localparam int          SCR64_TAP_B        = 57;
	localparam int          K_FRAMES_DEF       = 32;
	localparam int          K_FRAMES_MIN       = 17;
	localparam int          K_FRAMES_MAX       = 128;
	localparam int          EXT_MBLOCKS_DEF    = 1;
	localparam int          BUF_DEPTH          = 2;
	localparam logic [15:0] BLOCK_OCTETS       = 16'h0008;
	localparam logic [15:0] MBLOCK_BLOCKS      = 16'h0020;
	localparam logic [15:0] SYNC_REINIT_FRAMES = 16'h0004;
	localparam logic [1:0]  ILAS_LAST_MF       = 2'h3;
	localparam logic [7:0]  CHAR_COMMA         = 8'hBC;
	localparam logic [7:0]  CHAR_MF_START      = 8'h1C;
	localparam logic [7:0]  CHAR_MF_END        = 8'h7C;
	localparam logic [7:0]  CHAR_CFG_START     = 8'h9C;
	localparam logic [1:0]  HDR_DATA           = 2'h1;
	// active lanes per transport mode; octets per frame follow as 8 / lanes
	localparam logic [3:0]  MODE_LANES [4]     = '{4'h8, 4'h4, 4'h2, 4'h1};

	typedef enum logic [1:0] {
		ST_CGS  = 2'b00,
		ST_WAIT = 2'b01,
		ST_ILAS = 2'b10,
		ST_DATA = 2'b11
	} jtf_state_t;
endpackage

// ==== jtf_buf.sv ====
`timescale 1ns/100ps
module jtf_buf #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("jtf_buf: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             full_reg;
	wire              push = in_valid && !full_reg;
	wire              pop  = out_ready && (count_reg != '0);
	wire  [AW:0]      count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	assign in_ready  = !full_reg;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_sys) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			full_reg   <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_next;
			full_reg   <= (count_next == (AW+1)'(DEPTH));
		end
	end
endmodule

// ==== jtf_framer_asserts.sv ====
`timescale 1ns/100ps
module jtf_chk (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	// configuration and pins
	input wire logic        line_enc_64b,
	input wire logic [1:0]  transport_mode_select,
	input wire logic        fec_enable,
	input wire logic        single_channel,
	input wire logic        sync_n_pin,
	input wire logic        ser_ready,
	// lane side
	input wire logic [63:0] lane_octet,
	input wire logic [7:0]  lane_is_k,
	input wire logic [7:0]  lane_enable,
	input wire logic        octet_valid,
	input wire logic        hdr_valid,
	input wire logic [1:0]  lane_hdr,
	input wire logic        fec_active,
	input wire logic        nco_sync_pulse,
	input wire logic        link_up
);
	logic [5:0]      low_ticks;
	wire logic [2:0] lane_shift = (transport_mode_select == 2'h0) ? (single_channel ? 3'h4 : 3'h0) :
		(transport_mode_select == 2'h1) ? 3'h4 : (transport_mode_select == 2'h2) ? 3'h6 : 3'h7;
	wire logic [7:0] lane_exp   = 8'hFF >> lane_shift;
	// octet ticks with sync held low, saturating
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			low_ticks <= 6'h00;
		end else if (sync_n_pin) begin
			low_ticks <= 6'h00;
		end else if (ser_ready && low_ticks != 6'h3F) begin
			low_ticks <= low_ticks + 6'h01;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_CGS_COMMA: assert property (!line_enc_64b && low_ticks > 6'h28 && octet_valid |->
		lane_octet[7:0] == 8'hBC && lane_is_k[0]) else $error("no comma on lane 0");
	AST_CGS_DOWN: assert property (!line_enc_64b && low_ticks > 6'h28 |-> !link_up)
		else $error("link up during sync request");
	AST_ILAS_END: assert property (!line_enc_64b && $rose(link_up) |->
		lane_octet[7:0] == 8'h7C && lane_is_k[0]) else $error("data not after alignment end");
	AST_HDR_64: assert property (line_enc_64b |=> lane_hdr == 2'h1) else $error("bad header");
	AST_HDR_8: assert property (!line_enc_64b |=> lane_hdr == 2'h0 && !hdr_valid)
		else $error("header in 8b10b");
	AST_HDR_TICK: assert property (hdr_valid |-> line_enc_64b && $past(ser_ready))
		else $error("header without tick");
	AST_SYNC_IGN: assert property (line_enc_64b && link_up |=> link_up) else $error("64b66b link lost");
	AST_NCO_8B: assert property (!line_enc_64b |=> !nco_sync_pulse) else $error("nco pulse in 8b10b");
	AST_FEC: assert property (1'b1 |=> fec_active == $past(line_enc_64b && fec_enable))
		else $error("bad fec flag");
	AST_LANES: assert property (1'b1 |=> lane_enable == lane_exp) else $error("bad lane enable");
	AST_FREEZE: assert property (!ser_ready |=> !octet_valid && $stable(lane_octet))
		else $error("lanes moved without tick");
	cover property (!line_enc_64b && $rose(link_up));
	cover property (line_enc_64b && $rose(link_up));
	cover property (low_ticks == 6'h3F);
endmodule

bind jtf_framer jtf_chk jtf_chk_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .line_enc_64b(line_enc_64b), .fec_enable(fec_enable),
	.transport_mode_select(transport_mode_select), .single_channel(single_channel), .sync_n_pin(sync_n_pin),
	.ser_ready(ser_ready), .lane_octet(lane_octet), .lane_is_k(lane_is_k), .lane_enable(lane_enable),
	.octet_valid(octet_valid), .hdr_valid(hdr_valid), .lane_hdr(lane_hdr), .fec_active(fec_active),
	.nco_sync_pulse(nco_sync_pulse), .link_up(link_up)
);

// ==== jtf_rx_model.sv ====
`timescale 1ns/100ps
module jtf_rx_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// test controls
	input  wire logic       drop,
	input  wire logic       slow,
	// lane 0 from the framer
	input  wire logic [7:0] lane0_octet,
	input  wire logic       lane0_is_k,
	input  wire logic       octet_valid,
	// handshake and pacing
	output logic            sync_n_pin,
	output logic            ser_ready
);
	logic [2:0] comma_cnt;
	logic       phase;
	wire logic  comma_seen = octet_valid && lane0_is_k && lane0_octet == 8'hBC;
	// four commas in a row end the request; 64b66b lanes carry none, so sync stays low there
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			comma_cnt <= 3'h0;
			phase     <= 1'b0;
		end else begin
			phase <= ~phase;
			// a short drop is an error report; only commas seen during it force a new code group sync
			if (drop) begin
				if (comma_seen)
					comma_cnt <= 3'h0;
			end else if (comma_seen && comma_cnt != 3'h4) begin
				comma_cnt <= comma_cnt + 3'h1;
			end else if (octet_valid && !comma_seen && comma_cnt != 3'h4) begin
				comma_cnt <= 3'h0;
			end
		end
	end
	// released at once, not on a multiframe edge: both timing conventions allow it
	assign sync_n_pin = comma_cnt == 3'h4 && !drop;
	// slow pacing gives a tick every other cycle
	assign ser_ready = slow ? phase : 1'b1;
endmodule

// ==== tb_jesd204c_transmit_framing.sv ====
`timescale 1ns/100ps
module tb_jesd204c_transmit_framing;
	logic        clk_sys, sys_rst, line_enc_64b, scramble_enable, fec_enable, nco_sync_enable, single_channel;
	logic        sysref_pin, in_valid, in_ready, ser_ready, sync_n_pin, octet_valid, hdr_valid, fec_active;
	logic        nco_sync_pulse, link_up, drop, slow;
	logic [1:0]  transport_mode_select, lane_hdr;
	logic [47:0] in_samples;
	logic [63:0] lane_octet;
	logic [7:0]  lane_is_k, lane_enable;
	int          err_total, tests_run;
	int          nco_cnt = 0;
	jtf_framer #(.K_FRAMES(17)) jtf_framer_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .line_enc_64b(line_enc_64b),
		.transport_mode_select(transport_mode_select), .scramble_enable(scramble_enable),
		.fec_enable(fec_enable), .nco_sync_enable(nco_sync_enable), .single_channel(single_channel),
		.sync_n_pin(sync_n_pin), .sysref_pin(sysref_pin), .in_valid(in_valid), .in_samples(in_samples),
		.in_ready(in_ready), .ser_ready(ser_ready), .lane_octet(lane_octet), .lane_is_k(lane_is_k),
		.lane_enable(lane_enable), .octet_valid(octet_valid), .hdr_valid(hdr_valid), .lane_hdr(lane_hdr),
		.fec_active(fec_active), .nco_sync_pulse(nco_sync_pulse), .link_up(link_up)
	);
	jtf_rx_model jtf_rx_model_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .drop(drop), .slow(slow), .lane0_octet(lane_octet[7:0]),
		.lane0_is_k(lane_is_k[0]), .octet_valid(octet_valid), .sync_n_pin(sync_n_pin), .ser_ready(ser_ready)
	);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// pulses counted away from the launching edge
	always @(negedge clk_sys) begin
		if (nco_sync_pulse === 1'b1)
			nco_cnt++;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// a wait that ran out counts as a mismatch and ends the run
	task automatic bound(input int i, input int lim, input string what);
		if (i >= lim) begin
			chk(what, 64'h1, 64'h0);
			results();
		end
	endtask
	task automatic setup(input logic enc, input logic [1:0] mode, input logic single);
		sys_rst = 1'b1;
		line_enc_64b = enc;
		transport_mode_select = mode;
		single_channel = single;
		scramble_enable = enc;
		cyc(16);
		chk("in_ready in reset", 64'h1, in_ready);
		sys_rst = 1'b0;
		cyc(4);
	endtask
	task automatic push(input logic [47:0] s);
		int i;
		in_samples = s;
		in_valid = 1'b1;
		for (i = 0; i < 50 && in_ready !== 1'b1; i++) cyc(1);
		bound(i, 50, "in_ready");
		cyc(1);
	endtask
	task automatic grab(input logic [63:0] exp);
		int i;
		for (i = 0; i < 300 && !(octet_valid === 1'b1 && lane_octet !== 64'h0); i++) cyc(1);
		bound(i, 300, "data word");
		chk("lane word", exp, lane_octet);
		cyc(1);
	endtask
	task automatic wait_up;
		int i;
		for (i = 0; i < 3000 && link_up !== 1'b1; i++) cyc(1);
		bound(i, 3000, "link_up");
	endtask
	task automatic t_link8;
		int i;
		int n;
		setup(1'b0, 2'h0, 1'b0);
		chk("cgs octets", {8{8'hBC}}, lane_octet);
		chk("cgs k flags", 64'hFF, lane_is_k);
		chk("fec in 8b10b", 64'h0, fec_active);
		push(48'hABC123456789);
		push(48'h000FFF800001);
		in_valid = 1'b0;
		cyc(1);
		chk("in_ready when full", 64'h0, in_ready);
		n = 0;
		for (i = 0; i < 3000 && link_up !== 1'b1; i++) begin
			if (octet_valid === 1'b1 && (n > 0 || (lane_octet[7:0] === 8'h1C && lane_is_k[0] === 1'b1)))
				n++;
			if (n == 19 && octet_valid === 1'b1)
				chk("ilas config char", 64'h9C, lane_octet[7:0]);
			cyc(1);
		end
		bound(i, 3000, "link_up");
		if (octet_valid === 1'b1 && n > 0)
			n++;
		chk("ilas end char", 64'h7C, lane_octet[7:0]);
		chk("ilas length", 64'h44, 64'(n));
		cyc(1);
		grab(64'h90786045_3012C0AB);
		grab(64'h10000080_F0FF0000);
	endtask
	task automatic t_resync;
		slow = 1'b0;
		drop = 1'b1;
		cyc(2);
		drop = 1'b0;
		cyc(10);
		chk("link after short sync low", 64'h1, link_up);
		drop = 1'b1;
		cyc(50);
		chk("link after long sync low", 64'h0, link_up);
		chk("comma after long sync low", 64'hBC, lane_octet[7:0]);
		drop = 1'b0;
		wait_up();
	endtask
	task automatic t_modes;
		logic [2:0] sh;
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				sh = (m == 0) ? (s ? 3'h4 : 3'h0) : (m == 1) ? 3'h4 : (m == 2) ? 3'h6 : 3'h7;
				setup(1'b0, m[1:0], s[0]);
				chk("lane_enable", {56'h0, 8'hFF >> sh}, lane_enable);
			end
		end
	endtask
	task automatic t_enc64;
		int n;
		int nco0;
		nco0 = nco_cnt;
		setup(1'b1, 2'h1, 1'b0);
		cyc(100);
		sysref_pin = 1'b1;
		cyc(1);
		sysref_pin = 1'b0;
		cyc(200);
		chk("link held by sysref", 64'h0, link_up);
		wait_up();
		chk("fec flag", 64'h1, fec_active);
		chk("lane header", 64'h1, lane_hdr);
		n = 0;
		for (int i = 0; i < 64; i++) begin
			n += hdr_valid;
			cyc(1);
		end
		chk("block headers", 64'h8, 64'(n));
		chk("nco pulses without sync edge", 64'h0, 64'(nco_cnt - nco0));
	endtask
	initial begin
		err_total = 0;
		tests_run = 0;
		{sys_rst, line_enc_64b, scramble_enable, single_channel, sysref_pin, in_valid, drop} = 7'h40;
		{fec_enable, nco_sync_enable, slow} = 3'h7;
		transport_mode_select = 2'h0;
		in_samples = 48'h0;
		#1;
		t_link8();
		t_resync();
		t_modes();
		t_enc64();
		results();
	end
endmodule
